// ---- verilog/crt_xfer_seq.v ----
// core-side sequencer for coprocessor register transfers and the undefined trap
`include "crt_consts.vh"

// ==========================================================
// Contract
// - while busy is high repeat busy cycles at pc+8; transfer follows last one
// - coprocessor-to-core move writes one word to the register in cycle three
// - that third cycle may merge with the next prefetch as a nonsequential cycle
// - ready move fetches pc+8 in cycle one, pc+12 with coprocessor data in two
// - core-to-coprocessor move omits the write cycle: two or b+2 cycles
// - core-to-coprocessor transfer cycle writes source word at pc+12, nonsequential
// - coprocessor classes are not offered in the compressed 16-bit state; the undefined class still is
// - an instruction nobody executes, or undefined encoding, takes the undefined trap
// - trap cycles one and two hold pc+2L; memory requested only in cycle two
// - trap cycles three and four fetch vector and vector+4 in undefined mode
// - failed condition costs one sequential fetch of pc+2L, next address pc+3L
// - execution overlaps fetch and decode of the following instructions
// - core-to-coprocessor costs N+bI+C, coprocessor-to-core costs S+(b+1)I+C
// - data op costs S+bI; n-word coprocessor load or store (n-1)S+2N+bI
// - multiply term m from sign-extension of multiplier bytes; multiply S+mI
// - word load S+N+I plus S+N for pc; store 2N; branch and trap 2S+N
module crt_xfer_seq (
    input wire ref_clk_in, // core clock
    input wire rst_in, // async reset, active high
    input wire start_in, // instruction presented for execution
    input wire [3:0] class_in, // instruction class
    input wire cond_pass_in, // condition code met
    input wire [31:0] pc_in, // address of the instruction
    input wire [31:0] src_word_in, // source register for core-to-coprocessor
    input wire [31:0] cop_word_in, // data bus word read back
    input wire cop_absent_in, // coprocessor absent line
    input wire cop_busy_in, // coprocessor busy line
    input wire short_instr_state_in, // compressed 16-bit state
    input wire [1:0] access_size_in, // current access size
    input wire nonuser_in, // current privilege
    input wire [4:0] mode_in, // current mode
    input wire [31:0] trap_vector_addr_in, // undefined trap vector
    input wire merge_en_in, // merge write cycle with next prefetch
    input wire [7:0] cost_b_in, // busy cycles for classes not sequenced here
    input wire [4:0] n_words_in, // words moved by load or store classes
    input wire [31:0] mult_in, // multiplier operand
    input wire pc_loaded_in, // load writes the program counter
    output wire ready_out, // a new instruction can be taken this cycle
    output wire done_out, // last cycle of the current instruction
    output reg [31:0] addr_out, // memory address
    output reg [1:0] access_size_out, // access size
    output reg write_not_read_out, // write cycle
    output reg [31:0] wdata_out, // write data
    output reg data_oe_low_out, // low while the core drives the data bus
    output reg mem_request_low_out, // memory request, low active
    output wire burst_follow_flag_out, // sequential cycle follows
    output reg instr_fetch_low_out, // opcode fetch, low active
    output reg cop_instr_low_out, // coprocessor instruction, low active
    output reg nonuser_access_out, // privileged access
    output reg [4:0] mode_out, // processor mode
    output reg short_instr_state_out, // compressed state indicator
    output reg reg_we_out, // register write strobe
    output reg [31:0] reg_wdata_out, // register write word
    output reg trap_taken_out, // undefined trap entered
    output reg [31:0] resume_addr_out, // next fetch address after the instruction
    output reg cost_valid_out, // budget fields valid, one cycle
    output reg [7:0] cost_n_out, // nonsequential cycles
    output reg [7:0] cost_s_out, // sequential cycles
    output reg [7:0] cost_i_out, // internal cycles
    output reg [7:0] cost_c_out // coprocessor cycles
);

// ==========================================================
// states
localparam ST_IDLE = 4'h0;
localparam ST_DEC = 4'h1;
localparam ST_BUSY = 4'h2;
localparam ST_XFER = 4'h3;
localparam ST_WRB = 4'h4;
localparam ST_UND2 = 4'h5;
localparam ST_UND3 = 4'h6;
localparam ST_UND4 = 4'h7;
localparam ST_SKIP = 4'h8;
localparam ST_FIN = 4'h9;

// ==========================================================
// decoders
function [31:0] pc_step;
    input sh;
    input [1:0] k;
    begin
        pc_step = sh ? {29'h0, k, 1'h0} : {28'h0, k, 2'h0};
    end
endfunction

function is_cop;
    input [3:0] cls;
    begin
        is_cop = (cls == `CRT_CLS_MCR) || (cls == `CRT_CLS_MRC);
    end
endfunction

// ==========================================================
// captured instruction context
reg [3:0] state, next_state, class_q;
reg [31:0] pc_q, vec_q, src_q, mult_q;
reg short_q, nonuser_q, merge_q, cond_fail_q, und_q, trapped_q, seq_q, pcld_q;
reg [1:0] size_q;
reg [4:0] mode_q, n_words_q;
reg [7:0] cost_b_q;

wire last = (state == ST_XFER && class_q == `CRT_CLS_MCR) || state == ST_WRB ||
    state == ST_UND4 || state == ST_SKIP || state == ST_FIN;
assign ready_out = (state == ST_IDLE) || last;
assign done_out = last;
wire take = start_in && ready_out;

wire [31:0] n_pc = take ? pc_in : pc_q;
wire [3:0] n_class = take ? class_in : class_q;
wire n_short = take ? short_instr_state_in : short_q;
wire [1:0] n_size = take ? access_size_in : size_q;
wire n_nonuser = take ? nonuser_in : nonuser_q;
wire [4:0] n_mode = take ? mode_in : mode_q;
wire [31:0] n_vec = take ? trap_vector_addr_in : vec_q;
wire [31:0] n_src = take ? src_word_in : src_q;
wire n_merge = take ? merge_en_in : merge_q;
// coprocessor encodings in the compressed state are never offered
wire start_und = class_in == `CRT_CLS_UNDEF ||
    (is_cop(class_in) && short_instr_state_in);
wire n_und = take ? start_und : und_q;
wire start_seq = is_cop(class_in) || class_in == `CRT_CLS_UNDEF;
wire [3:0] start_tgt = !cond_pass_in ? ST_SKIP : (start_seq ? ST_DEC : ST_FIN);

// ==========================================================
// next state
always @* begin
    next_state = state;
    if (ready_out) begin
        next_state = take ? start_tgt : ST_IDLE;
    end else begin
        case (state)
            ST_DEC, ST_BUSY: begin
                if (und_q || cop_absent_in) begin
                    next_state = ST_UND2;
                end else if (cop_busy_in) begin
                    next_state = ST_BUSY;
                end else begin
                    next_state = ST_XFER;
                end
            end
            ST_XFER: next_state = ST_WRB;
            ST_UND2: next_state = ST_UND3;
            ST_UND3: next_state = ST_UND4;
            default: next_state = ST_IDLE;
        endcase
    end
end

// ==========================================================
// bus values for the coming cycle
reg [31:0] next_addr, next_wdata;
reg [1:0] next_size;
reg [4:0] next_mode;
reg next_wnr, next_oe_low, next_mreq_low, next_seq, next_opc_low, next_cpi_low;
reg next_nonuser, next_short;

always @* begin
    next_addr = addr_out;
    next_size = n_size;
    next_wnr = 1'h0;
    next_wdata = wdata_out;
    next_oe_low = 1'h1;
    next_mreq_low = 1'h1;
    next_seq = 1'h0;
    next_opc_low = 1'h1;
    next_cpi_low = 1'h1;
    next_nonuser = n_nonuser;
    next_mode = n_mode;
    next_short = n_short;
    case (next_state)
        ST_DEC, ST_BUSY: begin
            next_addr = n_pc + pc_step(n_short, `CRT_STEP_2L);
            next_opc_low = next_state != ST_DEC;
            next_cpi_low = next_state == ST_DEC && n_short && is_cop(n_class);
        end
        ST_XFER: begin
            next_addr = n_pc + `CRT_OFS_XFER;
            if (n_class == `CRT_CLS_MCR) begin
                next_wnr = 1'h1;
                next_wdata = n_src;
                next_oe_low = 1'h0;
                next_mreq_low = 1'h0;
            end
        end
        ST_WRB: begin
            next_addr = n_pc + `CRT_OFS_XFER;
            next_mreq_low = 1'h0;
            next_seq = !n_merge;
        end
        ST_UND2, ST_SKIP: begin
            next_addr = n_pc + pc_step(n_short, `CRT_STEP_2L);
            next_mreq_low = 1'h0;
            next_seq = next_state == ST_SKIP;
            next_opc_low = 1'h0;
        end
        ST_UND3, ST_UND4: begin
            next_addr = (next_state == ST_UND3) ? n_vec : n_vec + `CRT_OFS_VEC_STEP;
            next_size = `CRT_SIZE_WORD;
            next_mreq_low = 1'h0;
            next_seq = 1'h1;
            next_opc_low = 1'h0;
            next_nonuser = 1'h1;
            next_mode = `CRT_MODE_UNDEF;
            next_short = 1'h0;
        end
        default: next_addr = addr_out;
    endcase
end

// the final busy cycle announces the transfer as soon as busy drops
wire handshake_cycle = (state == ST_DEC && !und_q) || state == ST_BUSY;
assign burst_follow_flag_out = handshake_cycle ? (!cop_busy_in && !cop_absent_in) : seq_q;

// ==========================================================
// busy-wait count and budget
wire [7:0] busy_cycles, cost_n, cost_s, cost_i, cost_c;
wire busy_step = handshake_cycle && cop_busy_in && !cop_absent_in;
wire [3:0] cost_class = trapped_q ? `CRT_CLS_TRAP : class_q;
wire [7:0] cost_b = is_cop(class_q) ? busy_cycles : cost_b_q;

crt_bwait u_bwait (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clear_in(take), .step_in(busy_step),
    .busy_cycles_out(busy_cycles)
);

crt_cost u_cost (
    .class_in(cost_class), .cond_fail_in(cond_fail_q), .busy_cycles_in(cost_b),
    .n_words_in(n_words_q), .mult_in(mult_q), .pc_loaded_in(pcld_q),
    .n_cnt_out(cost_n), .s_cnt_out(cost_s), .i_cnt_out(cost_i), .c_cnt_out(cost_c)
);

// ==========================================================
// registers
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        state <= ST_IDLE;
        pc_q <= `CRT_RESET_ADDR;
        class_q <= `CRT_CLS_CDP;
        short_q <= 1'h0;
        size_q <= `CRT_SIZE_WORD;
        nonuser_q <= 1'h0;
        mode_q <= 5'h00;
        vec_q <= `CRT_RESET_ADDR;
        src_q <= 32'h0;
        merge_q <= 1'h0;
        cond_fail_q <= 1'h0;
        und_q <= 1'h0;
        trapped_q <= 1'h0;
        seq_q <= 1'h0;
        cost_b_q <= `CRT_CNT_ZERO;
        n_words_q <= 5'h00;
        mult_q <= 32'h0;
        pcld_q <= 1'h0;
        addr_out <= `CRT_RESET_ADDR;
        access_size_out <= `CRT_SIZE_WORD;
        write_not_read_out <= 1'h0;
        wdata_out <= 32'h0;
        data_oe_low_out <= 1'h1;
        mem_request_low_out <= 1'h1;
        instr_fetch_low_out <= 1'h1;
        cop_instr_low_out <= 1'h1;
        nonuser_access_out <= 1'h0;
        mode_out <= 5'h00;
        short_instr_state_out <= 1'h0;
        reg_we_out <= 1'h0;
        reg_wdata_out <= 32'h0;
        trap_taken_out <= 1'h0;
        resume_addr_out <= `CRT_RESET_ADDR;
        cost_valid_out <= 1'h0;
        cost_n_out <= `CRT_CNT_ZERO;
        cost_s_out <= `CRT_CNT_ZERO;
        cost_i_out <= `CRT_CNT_ZERO;
        cost_c_out <= `CRT_CNT_ZERO;
    end else begin
        state <= next_state;
        pc_q <= n_pc;
        class_q <= n_class;
        short_q <= n_short;
        size_q <= n_size;
        nonuser_q <= n_nonuser;
        mode_q <= n_mode;
        vec_q <= n_vec;
        src_q <= n_src;
        merge_q <= n_merge;
        und_q <= n_und;
        if (take) begin
            cond_fail_q <= !cond_pass_in;
            trapped_q <= 1'h0;
            cost_b_q <= cost_b_in;
            n_words_q <= n_words_in;
            mult_q <= mult_in;
            pcld_q <= pc_loaded_in;
        end else if (next_state == ST_UND2) begin
            trapped_q <= 1'h1;
        end
        addr_out <= next_addr;
        access_size_out <= next_size;
        write_not_read_out <= next_wnr;
        wdata_out <= next_wdata;
        data_oe_low_out <= next_oe_low;
        mem_request_low_out <= next_mreq_low;
        seq_q <= next_seq;
        instr_fetch_low_out <= next_opc_low;
        cop_instr_low_out <= next_cpi_low;
        nonuser_access_out <= next_nonuser;
        mode_out <= next_mode;
        short_instr_state_out <= next_short;
        // the coprocessor word is on the bus during the transfer cycle
        if (state == ST_XFER && class_q == `CRT_CLS_MRC) begin
            reg_wdata_out <= cop_word_in;
        end
        reg_we_out <= next_state == ST_WRB;
        trap_taken_out <= next_state == ST_UND3;
        cost_valid_out <= last;
        if (last) begin
            resume_addr_out <= (state == ST_SKIP) ? pc_q + pc_step(short_q, `CRT_STEP_3L) :
                (state == ST_UND4) ? addr_out + `CRT_OFS_VEC_STEP :
                pc_q + `CRT_OFS_XFER;
            cost_n_out <= cost_n;
            cost_s_out <= cost_s;
            cost_i_out <= cost_i;
            cost_c_out <= cost_c;
        end
    end
end

endmodule // crt_xfer_seq

// ---- inc/crt_consts.vh ----
// shared constants of the coprocessor register transfer sequencer
`ifndef CRT_CONSTS_VH
`define CRT_CONSTS_VH

// ==========================================================
// instruction classes
`define CRT_CLS_MCR 4'h0
`define CRT_CLS_MRC 4'h1
`define CRT_CLS_CDP 4'h2
`define CRT_CLS_LDST 4'h3
`define CRT_CLS_MUL 4'h4
`define CRT_CLS_LDR 4'h5
`define CRT_CLS_STR 4'h6
`define CRT_CLS_BRANCH 4'h7
`define CRT_CLS_TRAP 4'h8
`define CRT_CLS_UNDEF 4'h9

// ==========================================================
// address offsets from the instruction and vector addresses, and the reset address
`define CRT_OFS_XFER 32'h0000000c
`define CRT_OFS_VEC_STEP 32'h00000004
`define CRT_RESET_ADDR 32'h00000000

// ==========================================================
// bus field values
`define CRT_SIZE_WORD 2'h2
`define CRT_MODE_UNDEF 5'h04
`define CRT_STEP_2L 2'h2
`define CRT_STEP_3L 2'h3

// ==========================================================
// cycle budget figures
`define CRT_CNT_ZERO 8'h00
`define CRT_CNT_ONE 8'h01
`define CRT_CNT_TWO 8'h02
`define CRT_CNT_MAX 8'hff

`endif

// ---- verilog/crt_bwait.v ----
// busy-wait cycle counter of the coprocessor handshake
`include "crt_consts.vh"

module crt_bwait (
    input wire ref_clk_in, // core clock
    input wire rst_in, // async reset, active high
    input wire clear_in, // restart count for a new instruction
    input wire step_in, // one cycle with the coprocessor busy
    output reg [7:0] busy_cycles_out // busy cycles seen so far
);

// ==========================================================
// saturating counter
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        busy_cycles_out <= `CRT_CNT_ZERO;
    end else if (clear_in) begin
        busy_cycles_out <= `CRT_CNT_ZERO;
    end else if (step_in && busy_cycles_out != `CRT_CNT_MAX) begin
        busy_cycles_out <= busy_cycles_out + `CRT_CNT_ONE;
    end
end

endmodule // crt_bwait

// ---- verilog/crt_cost.v ----
// incremental cycle budget of one instruction class
`include "crt_consts.vh"

module crt_cost (
    input wire [3:0] class_in, // instruction class
    input wire cond_fail_in, // condition code not met
    input wire [7:0] busy_cycles_in, // b, busy-wait cycles
    input wire [4:0] n_words_in, // n, words moved
    input wire [31:0] mult_in, // multiplier operand
    input wire pc_loaded_in, // load writes the program counter
    output reg [7:0] n_cnt_out, // nonsequential cycles
    output reg [7:0] s_cnt_out, // sequential cycles
    output reg [7:0] i_cnt_out, // internal cycles
    output reg [7:0] c_cnt_out // coprocessor cycles
);

// ==========================================================
// multiplier early-termination term
function [2:0] mult_term;
    input [31:0] v;
    integer k;
    begin
        mult_term = 3'h4;
        for (k = 3; k > 0; k = k - 1) begin
            if ((v >> (8 * k)) == 32'h0 || (v >> (8 * k)) == (32'hffffffff >> (8 * k))) begin
                mult_term = k[2:0];
            end
        end
    end
endfunction

wire [7:0] words = {3'h0, n_words_in};
wire [7:0] m_term = {5'h0, mult_term(mult_in)};

// ==========================================================
// budget per class
always @* begin
    n_cnt_out = `CRT_CNT_ZERO;
    s_cnt_out = `CRT_CNT_ZERO;
    i_cnt_out = `CRT_CNT_ZERO;
    c_cnt_out = `CRT_CNT_ZERO;
    if (cond_fail_in) begin
        s_cnt_out = `CRT_CNT_ONE;
    end else begin
        case (class_in)
            `CRT_CLS_MCR: begin
                n_cnt_out = `CRT_CNT_ONE;
                i_cnt_out = busy_cycles_in;
                c_cnt_out = `CRT_CNT_ONE;
            end
            `CRT_CLS_MRC: begin
                s_cnt_out = `CRT_CNT_ONE;
                i_cnt_out = busy_cycles_in + `CRT_CNT_ONE;
                c_cnt_out = `CRT_CNT_ONE;
            end
            `CRT_CLS_CDP: begin
                s_cnt_out = `CRT_CNT_ONE;
                i_cnt_out = busy_cycles_in;
            end
            `CRT_CLS_LDST: begin
                s_cnt_out = (words == `CRT_CNT_ZERO) ? `CRT_CNT_ZERO : words - `CRT_CNT_ONE;
                n_cnt_out = `CRT_CNT_TWO;
                i_cnt_out = busy_cycles_in;
            end
            `CRT_CLS_MUL: begin
                s_cnt_out = `CRT_CNT_ONE;
                i_cnt_out = m_term;
            end
            `CRT_CLS_LDR: begin
                s_cnt_out = pc_loaded_in ? `CRT_CNT_TWO : `CRT_CNT_ONE;
                n_cnt_out = pc_loaded_in ? `CRT_CNT_TWO : `CRT_CNT_ONE;
                i_cnt_out = `CRT_CNT_ONE;
            end
            `CRT_CLS_STR: begin
                n_cnt_out = `CRT_CNT_TWO;
            end
            `CRT_CLS_BRANCH, `CRT_CLS_TRAP, `CRT_CLS_UNDEF: begin
                s_cnt_out = `CRT_CNT_TWO;
                n_cnt_out = `CRT_CNT_ONE;
            end
            default: begin
                n_cnt_out = `CRT_CNT_ZERO;
            end
        endcase
    end
end

endmodule // crt_cost

// ---- verif/crt_xfer_seq_props.sv ----
// checker of the transfer sequencer ports
module crt_xfer_seq_props (
    input ref_clk_in, // clock
    input rst_in, // reset
    input start_in, // seen
    input cond_pass_in, // seen
    input [31:0] src_word_in, // seen
    input [31:0] cop_word_in, // seen
    input cop_absent_in, // seen
    input cop_busy_in, // seen
    input ready_out, // seen
    input done_out, // seen
    input [31:0] addr_out, // seen
    input write_not_read_out, // seen
    input [31:0] wdata_out, // seen
    input data_oe_low_out, // seen
    input mem_request_low_out, // seen
    input burst_follow_flag_out, // seen
    input instr_fetch_low_out, // seen
    input cop_instr_low_out, // seen
    input nonuser_access_out, // seen
    input [4:0] mode_out, // seen
    input short_instr_state_out, // seen
    input reg_we_out, // seen
    input [31:0] reg_wdata_out, // seen
    input trap_taken_out // seen
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // handshake
    property p_busy;
        !cop_instr_low_out && cop_busy_in && !cop_absent_in |-> !burst_follow_flag_out
            ##1 !cop_instr_low_out && mem_request_low_out && addr_out == $past(addr_out);
    endproperty
    a_busy: assert property (p_busy) else $error("busy wait broken");
    property p_go;
        !cop_instr_low_out && !cop_busy_in && !cop_absent_in |-> burst_follow_flag_out
            ##1 cop_instr_low_out && addr_out == $past(addr_out) + 32'h4;
    endproperty
    a_go: assert property (p_go) else $error("transfer did not follow");
    property p_absent;
        !cop_instr_low_out && cop_absent_in |=> cop_instr_low_out && !mem_request_low_out
            ##1 trap_taken_out;
    endproperty
    a_absent: assert property (p_absent) else $error("absent not trapped");
    // ==========================================================
    // transfer cycles
    property p_mcr;
        write_not_read_out |-> !data_oe_low_out && !mem_request_low_out && done_out
            && !burst_follow_flag_out && wdata_out == src_word_in;
    endproperty
    a_mcr: assert property (p_mcr) else $error("write cycle wrong");
    property p_mrc_wr;
        reg_we_out |-> !mem_request_low_out && addr_out == $past(addr_out)
            && reg_wdata_out == $past(cop_word_in);
    endproperty
    a_mrc_wr: assert property (p_mrc_wr) else $error("register write wrong");
    // ==========================================================
    // trap and failed condition
    property p_trap12;
        trap_taken_out |-> $past(cop_instr_low_out) && !$past(mem_request_low_out)
            && $past(mem_request_low_out, 2) && $past(addr_out, 2) == $past(addr_out);
    endproperty
    a_trap12: assert property (p_trap12) else $error("trap start wrong");
    property p_vec;
        trap_taken_out |-> mode_out == 5'h04 && nonuser_access_out && !short_instr_state_out
            && burst_follow_flag_out ##1 addr_out == $past(addr_out) + 32'h4 && done_out;
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch wrong");
    property p_cfail;
        start_in && ready_out && !cond_pass_in |=> !mem_request_low_out && done_out
            && burst_follow_flag_out && !instr_fetch_low_out;
    endproperty
    a_cfail: assert property (p_cfail) else $error("skip cycle wrong");
    c_mrc: cover property (reg_we_out);
    c_mcr: cover property (write_not_read_out);
    c_trap: cover property (trap_taken_out);
endmodule // crt_xfer_seq_props

bind crt_xfer_seq crt_xfer_seq_props u_props (.*);

// ---- verif/crt_cop_model.sv ----
// coprocessor model answering the handshake
module crt_cop_model (
    input ref_clk_in, // clock
    input rst_in, // reset
    input cop_instr_low_in, // instruction offered
    input [3:0] busy_n_in, // busy cycles to insert
    input absent_in, // nobody claims it
    input [31:0] word_in, // word handed back
    output wire cop_absent_out, // absent line
    output wire cop_busy_out, // busy line
    output wire [31:0] cop_word_out // data bus word
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] cnt;
    reg cpi_q;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 4'h0;
            cpi_q <= 1'b1;
        end else begin
            cpi_q <= cop_instr_low_in;
            cnt <= cop_instr_low_in ? 4'h0 : cnt + 4'h1;
        end
    end
    // both lines high unless an instruction is offered
    assign cop_absent_out = cop_instr_low_in | absent_in;
    assign cop_busy_out = cop_instr_low_in | (cnt < busy_n_in);
    // word only right after the offer, inverse otherwise
    assign cop_word_out = (!cpi_q && cop_instr_low_in) ? word_in : ~word_in;
endmodule // crt_cop_model

// ---- verif/crt_xfer_seq_tb.sv ----
// testbench of the coprocessor register transfer sequencer
module crt_xfer_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'b0, rst = 1'b1, start = 1'b0, cond = 1'b1, sh = 1'b0, mg = 1'b0, ab = 1'b0;
    reg [3:0] cls = 4'h0, nb = 4'h0;
    reg [7:0] cb = 8'h0;
    reg [31:0] pc = 32'h0, mul = 32'h0, src_w = 32'h5a5a00f1, cop_w = 32'hc3c3a55a;
    reg [31:0] vec = 32'h0000001c;
    wire cop_absent, cop_busy, rdy, done, wnr, mreq, seq, opc, cpi, rwe, trap, cv;
    wire [4:0] mo;
    wire [7:0] cn, cs, ci, cc;
    wire [31:0] cw, addr, wd, rwd, res;
    int n_tests = 0;
    int n_mismatch = 0;
    always #2.5 clk = ~clk;
    crt_xfer_seq dut (.ref_clk_in(clk), .rst_in(rst), .start_in(start), .class_in(cls),
        .cond_pass_in(cond), .pc_in(pc), .src_word_in(src_w), .cop_word_in(cw),
        .cop_absent_in(cop_absent), .cop_busy_in(cop_busy), .short_instr_state_in(sh),
        .access_size_in(2'h2), .nonuser_in(1'b0), .mode_in(5'h13),
        .trap_vector_addr_in(vec), .merge_en_in(mg), .cost_b_in(cb), .n_words_in(5'h1),
        .mult_in(mul), .pc_loaded_in(1'b0), .ready_out(rdy), .done_out(done),
        .addr_out(addr), .access_size_out(), .write_not_read_out(wnr), .wdata_out(wd),
        .data_oe_low_out(), .mem_request_low_out(mreq), .burst_follow_flag_out(seq),
        .instr_fetch_low_out(opc), .cop_instr_low_out(cpi), .nonuser_access_out(),
        .mode_out(mo), .short_instr_state_out(), .reg_we_out(rwe), .reg_wdata_out(rwd),
        .trap_taken_out(trap), .resume_addr_out(res), .cost_valid_out(cv),
        .cost_n_out(cn), .cost_s_out(cs), .cost_i_out(ci), .cost_c_out(cc));
    crt_cop_model cop (.ref_clk_in(clk), .rst_in(rst), .cop_instr_low_in(cpi),
        .busy_n_in(nb), .absent_in(ab), .word_in(cop_w), .cop_absent_out(cop_absent),
        .cop_busy_out(cop_busy), .cop_word_out(cw));
    // ==========================================================
    // shared tasks
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task issue(input [3:0] c, input [31:0] p);
        @(negedge clk);
        cls = c;
        pc = p;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask
    task cost(input [31:0] e);
        repeat (50) begin
            if (cv !== 1'b1) @(negedge clk);
        end
        chk({cn, cs, ci, cc}, e, "cost");
        @(negedge clk);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task t_xfer(input [3:0] c, input [3:0] b, input m);
        int k;
        nb = b;
        mg = m;
        issue(c, 32'h100);
        for (k = 0; k <= b; k++) begin
            chk(addr, 32'h108, "addr_wait");
            chk(seq, k == b, "seq_wait");
            @(negedge clk);
        end
        chk(addr, 32'h10c, "addr_xfer");
        chk(wnr, c == 4'h0, "wnr");
        if (c == 4'h0) begin
            chk(wd, src_w, "wdata");
            chk(done, 1'b1, "done_mcr");
            cost({8'h1, 8'h0, 8'(b), 8'h1});
        end else begin
            @(negedge clk);
            chk(rwe, 1'b1, "reg_we");
            chk(rwd, cop_w, "reg_wdata");
            chk(seq, !m, "seq_wr");
            cost({8'h0, 8'h1, 8'(b) + 8'h1, 8'h1});
        end
        $display("transfer test done");
    endtask
    task t_trap(input [3:0] c, input s);
        ab = 1'b1;
        sh = s;
        issue(c, 32'h300);
        chk(addr, s ? 32'h304 : 32'h308, "addr_t1");
        chk(cpi, s, "cpi_t1");
        chk(mreq, 1'b1, "mreq_t1");
        @(negedge clk);
        chk({mreq, cpi}, 2'h1, "t2");
        @(negedge clk);
        chk(addr, vec, "vector");
        chk({trap, mo}, {1'b1, 5'h04}, "mode");
        @(negedge clk);
        chk(addr, vec + 32'h4, "vector4");
        cost({8'h1, 8'h2, 8'h0, 8'h0});
        chk(res, vec + 32'h8, "resume");
        ab = 1'b0;
        sh = 1'b0;
        $display("trap test done");
    endtask
    task t_cfail;
        cond = 1'b0;
        issue(4'h5, 32'h400);
        cond = 1'b1;
        chk({mreq, seq, opc, done}, 4'h5, "skip");
        chk(addr, 32'h408, "addr_skip");
        @(negedge clk);
        chk(res, 32'h40c, "resume_skip");
        cost({8'h0, 8'h1, 8'h0, 8'h0});
        $display("condition test done");
    endtask
    task t_cost;
        int k;
        for (k = 1; k <= 4; k++) begin
            mul = (k[0] ? 32'h0 : 32'hffffffff) ^ (32'h80 << (8 * (k - 1)));
            issue(4'h4, 32'h500);
            cost({8'h0, 8'h1, 8'(k), 8'h0});
        end
        cb = 8'h3;
        issue(4'h2, 32'h500);
        cost({8'h0, 8'h1, 8'h3, 8'h0});
        issue(4'h5, 32'h500);
        cost({8'h1, 8'h1, 8'h1, 8'h0});
        issue(4'h6, 32'h500);
        cost({8'h2, 8'h0, 8'h0, 8'h0});
        issue(4'h7, 32'h500);
        cost({8'h1, 8'h2, 8'h0, 8'h0});
        $display("cost test done");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_xfer(4'h1, 4'h0, 1'b0);
        t_xfer(4'h1, 4'h2, 1'b1);
        t_xfer(4'h0, 4'h0, 1'b0);
        t_xfer(4'h0, 4'h2, 1'b0);
        t_trap(4'h1, 1'b0);
        t_trap(4'h9, 1'b0);
        t_trap(4'h1, 1'b1);
        t_cfail;
        t_cost;
        conclude;
    end
    initial begin
        #10000;
        n_mismatch++;
        conclude;
    end
endmodule // crt_xfer_seq_tb
